/* File: src/edge_detect.sv */
// edge detector for one timer input with selectable valid edge
`timescale 1ns/1ps
`default_nettype none
`include "tmr_cfg.svh"

module edge_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sig,
    input wire logic [1:0] edge_sel,
    output logic valid_edge,
    output logic opposite_edge
);
    tmr_pkg::edge_state_t s_q;
    tmr_pkg::edge_state_t s_d;
    logic rise;
    logic fall;

    // classify the change against the selected valid edge
    always_comb begin
        rise = sig & ~s_q.prev;
        fall = ~sig & s_q.prev;
        s_d = s_q;
        s_d.prev = sig;
        case (edge_sel)
            `TMR_EDGE_FALL: begin
                s_d.valid = fall;
                s_d.opposite = rise;
            end
            `TMR_EDGE_RISE: begin
                s_d.valid = rise;
                s_d.opposite = fall;
            end
            `TMR_EDGE_BOTH: begin
                s_d.valid = rise | fall;
                s_d.opposite = 1'b0;
            end
            default: begin
                s_d.valid = 1'b0;
                s_d.opposite = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign valid_edge = s_q.valid;
    assign opposite_edge = s_q.opposite;
endmodule : edge_detect

`default_nettype wire

/* File: src/timer_oneshot_pulse_width_capture.sv */
// 16-bit timer channel: compare match, one-shot pulse and edge capture
`timescale 1ns/1ps
`default_nettype none
`include "tmr_cfg.svh"

// What this block does
// - match events when compare equals counter
// - one-shot only in modes 01/10 when enabled
// - trigger clears counter, emits one pulse
// - one-shot match A: event and toggle
// - one-shot match B: event and toggle
// - count register reads live without disturbing
// - two-input: A edge to B, B to A
// - single input: opposite edge A, valid B
// - clear mode: capture then clear on valid
// - register A trigger selects input A or B
// - overflow flag set on wrap outside mode 11, keep counting
// - mode 11: A sets period, B width
module timer_oneshot_pulse_width_capture (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic edge_input_a,
    input wire logic edge_input_b,
    output logic pulse_output,
    output logic pulse_output_en,
    output logic match_irq_a,
    output logic match_irq_b
);
    tmr_pkg::tmr_state_t s_q;
    tmr_pkg::tmr_state_t s_d;
    logic a_valid;
    logic a_opp;
    logic b_valid;
    logic b_opp;
    logic wr;
    logic setup;
    logic mapped;
    logic running;
    logic os_ok;
    logic soft_trig;
    logic trig;
    logic match_a;
    logic match_b;
    logic toggle_ok;
    logic cap_a_evt;
    logic cap_b_evt;
    logic [`TMR_ADDR_W-1:0] addr;

    // register offset decode
    function automatic logic is_mapped(input logic [`TMR_ADDR_W-1:0] a);
        case (a)
            `TMR_OFF_COUNT, `TMR_OFF_CCA, `TMR_OFF_CCB, `TMR_OFF_MODE,
            `TMR_OFF_CCCTL, `TMR_OFF_OUTCTL, `TMR_OFF_EDGE: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    edge_detect u_edge_a (
        .pclk(pclk),
        .presetn(presetn),
        .sig(edge_input_a),
        .edge_sel(s_q.edge_a),
        .valid_edge(a_valid),
        .opposite_edge(a_opp)
    );

    edge_detect u_edge_b (
        .pclk(pclk),
        .presetn(presetn),
        .sig(edge_input_b),
        .edge_sel(s_q.edge_b),
        .valid_edge(b_valid),
        .opposite_edge(b_opp)
    );

    // bus decode: zero wait states, error on unmapped offsets
    assign addr = paddr[`TMR_ADDR_W-1:0];
    assign mapped = is_mapped(addr) && (paddr[31:`TMR_ADDR_W] == '0);
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & mapped;
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped;

    // event terms of the counter
    assign running = (s_q.mode != tmp_stop());
    assign os_ok = s_q.os_en && (s_q.mode == tmr_pkg::MODE_FREE ||
        s_q.mode == tmr_pkg::MODE_CLEAR_ON_A);
    assign soft_trig = wr && addr == `TMR_OFF_OUTCTL &&
        pwdata[`TMR_OC_OSTRIG_BIT];
    assign trig = os_ok & (soft_trig | a_valid);
    assign match_a = running & ~s_q.cca_cap & (s_q.cnt == s_q.cca);
    assign match_b = running & ~s_q.ccb_cap & (s_q.cnt == s_q.ccb);
    assign toggle_ok = ~os_ok | s_q.os_active;
    assign cap_b_evt = running & s_q.ccb_cap & a_valid;
    assign cap_a_evt = running & s_q.cca_cap &
        (s_q.cca_sel_b ? b_valid : a_opp);

    function automatic tmr_pkg::op_mode_t tmp_stop();
        tmp_stop = tmr_pkg::MODE_STOP;
    endfunction : tmp_stop

    // next state of the whole channel
    always_comb begin
        s_d = s_q;
        s_d.irq_a = 1'b0;
        s_d.irq_b = 1'b0;
        // counter: stop, trigger clear, period clear, or count up
        if (!running) begin
            s_d.cnt = `TMR_CNT_ZERO;
        end else if (trig || (s_q.mode == tmr_pkg::MODE_CLEAR_ON_A &&
                a_valid)) begin
            s_d.cnt = `TMR_CNT_ZERO;
        end else if (s_q.mode == tmr_pkg::MODE_CLEAR_ON_MATCH && match_a) begin
            s_d.cnt = `TMR_CNT_ZERO;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
        // compare matches raise events and may toggle the output
        if (match_a) begin
            s_d.irq_a = 1'b1;
            if (s_q.inv_a && toggle_ok) begin
                s_d.out_lvl = ~s_q.out_lvl;
            end
            s_d.os_active = 1'b0;
        end
        if (match_b) begin
            s_d.irq_b = 1'b1;
            if (s_q.inv_b && toggle_ok) begin
                s_d.out_lvl = ~s_d.out_lvl;
            end
        end
        // captures of the live count
        if (cap_b_evt) begin
            s_d.ccb = s_q.cnt;
            s_d.irq_b = 1'b1;
        end
        if (cap_a_evt) begin
            s_d.cca = s_q.cnt;
            s_d.irq_a = 1'b1;
        end
        if (trig) begin
            s_d.os_active = 1'b1;
        end
        // register writes
        if (wr) begin
            case (addr)
                `TMR_OFF_CCA: s_d.cca = pwdata[15:0];
                `TMR_OFF_CCB: s_d.ccb = pwdata[15:0];
                `TMR_OFF_MODE: begin
                    s_d.mode = tmr_pkg::op_mode_t'(
                        pwdata[`TMR_MODE_HI_BIT:`TMR_MODE_LO_BIT]);
                    s_d.ovf = pwdata[`TMR_MODE_OVF_BIT];
                end
                `TMR_OFF_CCCTL: begin
                    s_d.cca_cap = pwdata[`TMR_CC_A_CAP_BIT];
                    s_d.cca_sel_b = pwdata[`TMR_CC_A_SELB_BIT];
                    s_d.ccb_cap = pwdata[`TMR_CC_B_CAP_BIT];
                end
                `TMR_OFF_OUTCTL: begin
                    s_d.drive_en = pwdata[`TMR_OC_DRIVE_BIT];
                    s_d.inv_a = pwdata[`TMR_OC_INVA_BIT];
                    s_d.inv_b = pwdata[`TMR_OC_INVB_BIT];
                    s_d.os_en = pwdata[`TMR_OC_OSEN_BIT];
                    if (!running && pwdata[`TMR_OC_PREHI_BIT] &&
                            !pwdata[`TMR_OC_PRELO_BIT]) begin
                        s_d.out_lvl = 1'b1;
                    end else if (!running && pwdata[`TMR_OC_PRELO_BIT] &&
                            !pwdata[`TMR_OC_PREHI_BIT]) begin
                        s_d.out_lvl = 1'b0;
                    end
                end
                `TMR_OFF_EDGE: begin
                    s_d.edge_a = pwdata[1:0];
                    s_d.edge_b = pwdata[3:2];
                end
                default: begin
                end
            endcase
        end
        // a wrap sets the flag, over a mode write too, but not in mode 11 or when a clear lands in the same cycle
        if (running && s_q.cnt == `TMR_CNT_MAX && s_d.cnt == `TMR_CNT_ZERO &&
                !(trig || (s_q.mode == tmr_pkg::MODE_CLEAR_ON_A && a_valid))
                && s_q.mode != tmr_pkg::MODE_CLEAR_ON_MATCH) begin
            s_d.ovf = 1'b1;
        end
        // read data is sampled in the setup cycle
        if (setup) begin
            case (addr)
                `TMR_OFF_COUNT: s_d.prdata = {16'h0000, s_q.cnt};
                `TMR_OFF_CCA: s_d.prdata = {16'h0000, s_q.cca};
                `TMR_OFF_CCB: s_d.prdata = {16'h0000, s_q.ccb};
                `TMR_OFF_MODE: s_d.prdata = {28'h0000000, s_q.mode, 1'b0,
                    s_q.ovf};
                `TMR_OFF_CCCTL: s_d.prdata = {29'h00000000, s_q.ccb_cap,
                    s_q.cca_sel_b, s_q.cca_cap};
                `TMR_OFF_OUTCTL: s_d.prdata = {26'h0000000, s_q.os_en,
                    s_q.inv_b, 2'h0, s_q.inv_a, s_q.drive_en};
                `TMR_OFF_EDGE: s_d.prdata = {28'h0000000, s_q.edge_b,
                    s_q.edge_a};
                default: s_d.prdata = 32'h00000000;
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.edge_a <= `TMR_EDGE_RESET;
            s_q.edge_b <= `TMR_EDGE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs come straight from the state register
    assign prdata = s_q.prdata;
    assign pulse_output = s_q.out_lvl;
    assign pulse_output_en = s_q.drive_en;
    assign match_irq_a = s_q.irq_a;
    assign match_irq_b = s_q.irq_b;

    // compare match A raises its event one cycle later
    match_a_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        match_a |=> match_irq_a) else $error("match A event missing");

    // compare match B raises its event one cycle later
    match_b_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        match_b |=> match_irq_b) else $error("match B event missing");

    // a one-shot trigger restarts the counter at zero
    trig_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        trig |=> (s_q.cnt == 16'h0000 && s_q.os_active))
        else $error("trigger did not restart counter");

    // no trigger is accepted outside modes 01 and 10
    oneshot_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.mode == tmr_pkg::MODE_STOP ||
        s_q.mode == tmr_pkg::MODE_CLEAR_ON_MATCH || !s_q.os_en) |-> !trig)
        else $error("trigger outside one-shot modes");

    // match A during a one-shot toggles the pin and ends the pulse
    os_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (match_a && !match_b && s_q.os_active && s_q.inv_a && !wr && !trig)
        |=> (pulse_output != $past(pulse_output) && !s_q.os_active))
        else $error("one-shot end wrong");

    // match B during a one-shot toggles the pin
    os_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        (match_b && !match_a && s_q.os_active && s_q.inv_b && !wr)
        |=> pulse_output != $past(pulse_output))
        else $error("one-shot start missing");

    // a valid A edge stores the live count in register B
    cap_b_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cap_b_evt && !wr) |=> (s_q.ccb == $past(s_q.cnt) && match_irq_b))
        else $error("capture into B wrong");

    // a register A trigger stores the live count in register A
    cap_a_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cap_a_evt && !wr) |=> (s_q.cca == $past(s_q.cnt) && match_irq_a))
        else $error("capture into A wrong");

    // clear-on-A mode clears the counter on the valid edge
    clear_on_a_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.mode == tmr_pkg::MODE_CLEAR_ON_A && a_valid)
        |=> s_q.cnt == 16'h0000) else $error("clear on edge failed");

    // free-running wrap sets the overflow flag and restarts at zero
    wrap_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.mode == tmr_pkg::MODE_FREE && s_q.cnt == 16'hFFFF && !trig)
        |=> (s_q.ovf && s_q.cnt == 16'h0000))
        else $error("overflow not flagged");

    // a count read returns the count seen in the setup cycle
    count_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && addr == `TMR_OFF_COUNT) |=> prdata == {16'h0000,
        $past(s_q.cnt)}) else $error("count read wrong");

    // mode 11 restarts the period at compare A
    ppg_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.mode == tmr_pkg::MODE_CLEAR_ON_MATCH && match_a)
        |=> s_q.cnt == 16'h0000) else $error("period not restarted");

    // free running advances by one every clock without a one-shot trigger, reads included
    free_count_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (s_q.mode == tmr_pkg::MODE_FREE && !trig)
        |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
        else $error("free count did not advance");

    // an armed one-shot keeps the pin still while no pulse runs
    os_idle_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (os_ok && !s_q.os_active && !trig)
        |=> pulse_output == $past(pulse_output))
        else $error("pin moved between pulses");
endmodule : timer_oneshot_pulse_width_capture

`default_nettype wire

/* File: src/tmr_cfg.svh */
// register offsets, field positions, reset values and limits of the timer
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

`define TMR_ADDR_W 8
`define TMR_OFF_COUNT 8'h00
`define TMR_OFF_CCA 8'h04
`define TMR_OFF_CCB 8'h08
`define TMR_OFF_MODE 8'h0C
`define TMR_OFF_CCCTL 8'h10
`define TMR_OFF_OUTCTL 8'h14
`define TMR_OFF_EDGE 8'h18

`define TMR_MODE_OVF_BIT 0
`define TMR_MODE_LO_BIT 2
`define TMR_MODE_HI_BIT 3

`define TMR_CC_A_CAP_BIT 0
`define TMR_CC_A_SELB_BIT 1
`define TMR_CC_B_CAP_BIT 2

`define TMR_OC_DRIVE_BIT 0
`define TMR_OC_INVA_BIT 1
`define TMR_OC_PRELO_BIT 2
`define TMR_OC_PREHI_BIT 3
`define TMR_OC_INVB_BIT 4
`define TMR_OC_OSEN_BIT 5
`define TMR_OC_OSTRIG_BIT 6

`define TMR_EDGE_FALL 2'h0
`define TMR_EDGE_RISE 2'h1
`define TMR_EDGE_NONE 2'h2
`define TMR_EDGE_BOTH 2'h3
`define TMR_EDGE_RESET 2'h2

`define TMR_CNT_MAX 16'hFFFF
`define TMR_CNT_ZERO 16'h0000

`endif

/* File: src/tmr_pkg.sv */
// types shared by the timer channel and its edge detector
package tmr_pkg;

    // operating mode in the order of its two-bit encoding
    typedef enum logic [1:0] {
        MODE_STOP,
        MODE_FREE,
        MODE_CLEAR_ON_A,
        MODE_CLEAR_ON_MATCH
    } op_mode_t;

    // edge detector state and result
    typedef struct packed {
        logic prev;
        logic valid;
        logic opposite;
    } edge_state_t;

    // whole state of the timer channel
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] cca;
        logic [15:0] ccb;
        op_mode_t mode;
        logic ovf;
        logic cca_cap;
        logic cca_sel_b;
        logic ccb_cap;
        logic drive_en;
        logic inv_a;
        logic inv_b;
        logic os_en;
        logic [1:0] edge_a;
        logic [1:0] edge_b;
        logic out_lvl;
        logic os_active;
        logic irq_a;
        logic irq_b;
        logic [31:0] prdata;
    } tmr_state_t;

endpackage : tmr_pkg

/* File: verification/pin_side.sv */
// far-side model that drives the two timer edge inputs
`timescale 1ns/1ps
`default_nettype none
module pin_side (
    input wire logic pclk,
    output logic in_a,
    output logic in_b
);
    // both inputs idle low until a test moves them
    initial begin
        in_a = 1'b0;
        in_b = 1'b0;
    end
    // move one input (0: a, 1: b) just after a rising edge
    task automatic drive(input logic which, input logic v);
        @(posedge pclk);
        if (which) begin
            in_b <= v;
        end else begin
            in_a <= v;
        end
    endtask : drive
endmodule : pin_side
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the timer channel
`timescale 1ns/1ps
`default_nettype none
`include "tmr_cfg.svh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pulse_output, pulse_output_en;
    logic match_irq_a, match_irq_b, in_a, in_b, er;
    logic [31:0] rd, v;
    int n_mismatch = 0;
    int compares = 0;
    int hi, na, nb;

    // 100 MHz clock
    always #5 pclk = ~pclk;

    timer_oneshot_pulse_width_capture dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .edge_input_a(in_a), .edge_input_b(in_b),
        .pulse_output(pulse_output), .pulse_output_en(pulse_output_en),
        .match_irq_a(match_irq_a), .match_irq_b(match_irq_b));
    pin_side far (.pclk(pclk), .in_a(in_a), .in_b(in_b));

    // compare one value with its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // print the counts and the verdict, then stop
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // one apb transfer; read data and error land in rd and er
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_mismatch++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // count output-high cycles and match pulses over a window
    task automatic meas(input int w);
        hi = 0;
        na = 0;
        nb = 0;
        repeat (w) begin
            @(posedge pclk);
            hi += (pulse_output === 1'b1);
            na += (match_irq_a === 1'b1);
            nb += (match_irq_b === 1'b1);
        end
    endtask : meas

    // park both inputs low, then set capture control and edges
    task automatic prep(input logic [31:0] ctl, input logic [31:0] edg);
        apb(1'b1, `TMR_OFF_EDGE, 32'hA);
        far.drive(1'b0, 1'b0);
        far.drive(1'b1, 1'b0);
        apb(1'b1, `TMR_OFF_CCCTL, ctl);
        apb(1'b1, `TMR_OFF_EDGE, edg);
    endtask : prep

    task automatic t_reset();
        apb(1'b0, `TMR_OFF_MODE, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `TMR_OFF_EDGE, 32'h0);
        check(rd, 32'hA);
        apb(1'b0, `TMR_OFF_OUTCTL, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, `TMR_OFF_COUNT, 32'h1234);
        apb(1'b0, `TMR_OFF_COUNT, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_count();
        apb(1'b1, `TMR_OFF_MODE, 32'h4);
        apb(1'b0, `TMR_OFF_COUNT, 32'h0);
        v = rd;
        apb(1'b0, `TMR_OFF_COUNT, 32'h0);
        check(rd - v, 32'h3);
        $display("test count done");
    endtask : t_count

    task automatic t_cap(input logic [31:0] ctl, input logic [31:0] edg,
                         input logic second);
        prep(ctl, edg);
        far.drive(1'b0, 1'b1);
        repeat (9) @(posedge pclk);
        far.drive(second, second);
        repeat (6) @(posedge pclk);
        apb(1'b0, `TMR_OFF_CCB, 32'h0);
        v = rd;
        apb(1'b0, `TMR_OFF_CCA, 32'h0);
        check(rd - v, 32'hA);
        $display("test capture done");
    endtask : t_cap

    task automatic t_clear();
        apb(1'b1, `TMR_OFF_MODE, 32'h8);
        prep(32'h5, 32'h9);
        far.drive(1'b0, 1'b1);
        repeat (7) @(posedge pclk);
        far.drive(1'b0, 1'b0);
        repeat (11) @(posedge pclk);
        far.drive(1'b0, 1'b1);
        repeat (6) @(posedge pclk);
        apb(1'b0, `TMR_OFF_CCB, 32'h0);
        v = rd;
        apb(1'b0, `TMR_OFF_CCA, 32'h0);
        check(v - rd, 32'hC);
        apb(1'b0, `TMR_OFF_COUNT, 32'h0);
        check({31'h0, rd < 32'h14}, 32'h1);
        // period kept short: no overflow, so no 10000H correction
        apb(1'b0, `TMR_OFF_MODE, 32'h0);
        check(rd, 32'h8);
        $display("test clear done");
    endtask : t_clear

    task automatic t_oneshot(input logic by_edge);
        apb(1'b1, `TMR_OFF_MODE, by_edge ? 32'h8 : 32'h4);
        prep(32'h0, 32'h9);
        apb(1'b1, `TMR_OFF_CCA, 32'h14);
        apb(1'b1, `TMR_OFF_CCB, 32'hA);
        // the enable must stand before a soft trigger is taken
        apb(1'b1, `TMR_OFF_OUTCTL, 32'h33);
        if (by_edge) begin
            far.drive(1'b0, 1'b1);
        end else begin
            apb(1'b1, `TMR_OFF_OUTCTL, 32'h73);
        end
        meas(60);
        check(hi, 32'hA);
        check(na, 32'h1);
        check(nb, 32'h1);
        check({31'h0, pulse_output_en}, 32'h1);
        // no further trigger while watching the idle level
        meas(100);
        check(hi, 32'h0);
        $display("test oneshot done");
    endtask : t_oneshot

    task automatic t_stopped();
        apb(1'b1, `TMR_OFF_MODE, 32'h0);
        apb(1'b1, `TMR_OFF_OUTCTL, 32'h73);
        meas(60);
        check(hi, 32'h0);
        check(na, 32'h0);
        $display("test stopped done");
    endtask : t_stopped

    task automatic t_ppg();
        apb(1'b1, `TMR_OFF_OUTCTL, 32'h13);
        apb(1'b1, `TMR_OFF_CCA, 32'hF);
        apb(1'b1, `TMR_OFF_CCB, 32'h5);
        apb(1'b1, `TMR_OFF_MODE, 32'hC);
        // window reaches the fourth match A of a 16-cycle period
        meas(65);
        check(na, 32'h4);
        check(nb, 32'h4);
        check({31'h0, hi == 40 || hi == 24}, 32'h1);
        $display("test ppg done");
    endtask : t_ppg

    task automatic t_ovf();
        apb(1'b1, `TMR_OFF_OUTCTL, 32'h0);
        apb(1'b1, `TMR_OFF_MODE, 32'h0);
        apb(1'b1, `TMR_OFF_MODE, 32'h4);
        apb(1'b0, `TMR_OFF_MODE, 32'h0);
        check(rd, 32'h4);
        repeat (65540) @(posedge pclk);
        apb(1'b0, `TMR_OFF_MODE, 32'h0);
        check(rd, 32'h5);
        apb(1'b1, `TMR_OFF_MODE, 32'h4);
        apb(1'b0, `TMR_OFF_MODE, 32'h0);
        check(rd, 32'h4);
        apb(1'b0, `TMR_OFF_COUNT, 32'h0);
        check({31'h0, rd < 32'h40}, 32'h1);
        $display("test overflow done");
    endtask : t_ovf

    // main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_count();
        t_cap(32'h7, 32'hF, 1'b1);
        t_cap(32'h5, 32'h9, 1'b0);
        t_clear();
        t_oneshot(1'b0);
        t_oneshot(1'b1);
        t_stopped();
        t_ppg();
        t_ovf();
        end_of_test();
    end

    // hang guard
    initial begin
        #900000;
        n_mismatch++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
